// ==== hdl/psm_pkg.sv ====
// Purpose: Constants and types for the PMBus status and manufacturer register bank
// Assumes: Registers are reached by PMBus command code through a simple access port
// Notes: The command decoder outside presents one access per command
package psm_pkg;
	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;
	localparam logic [7:0] CMD_COMM_STATUS = 8'h7e;
	localparam logic [7:0] CMD_VIN_READ = 8'h88;
	localparam logic [7:0] CMD_VOUT_READ = 8'h8b;
	localparam logic [7:0] CMD_IOUT_READ = 8'h8c;
	localparam logic [7:0] CMD_TEMP_READ = 8'h8d;
	localparam logic [7:0] CMD_DEV_TYPE = 8'hd0;
	localparam logic [7:0] CMD_VOUT_GAIN = 8'hd1;
	localparam logic [7:0] CMD_VOUT_OFS = 8'hd2;
	localparam logic [7:0] CMD_VIN_GAIN = 8'hd3;
	localparam logic [7:0] CMD_VIN_OFS = 8'hd4;
	localparam logic [7:0] CMD_IOUT_GAIN = 8'hd6;
	localparam logic [7:0] CMD_IOUT_OFS = 8'hd7;
	localparam logic [7:0] CMD_FW_REV = 8'hdb;
	localparam logic [7:0] CMD_PIN_CFG = 8'he0;
	// ----------------------------------------
	// Fields, masks and reset values
	// ----------------------------------------
	localparam logic [7:0] TEMP_MASK = 8'hc0;
	localparam logic [7:0] COMM_MASK = 8'he0;
	localparam int OVER_TEMP_FAULT_FLAG_BIT = 7;
	localparam int OVER_TEMP_WARN_FLAG_BIT = 6;
	localparam int BAD_CMD_BIT = 7;
	localparam int BAD_DATA_BIT = 6;
	localparam int PEC_FAIL_BIT = 5;
	localparam int WPE_BIT = 1;
	localparam int ARA_BIT = 4;
	localparam logic [7:0] PIN_CFG_MASK = 8'h1f;
	localparam logic [7:0] PIN_CFG_RESET = 8'h00;
	localparam logic [15:0] DEV_TYPE_MASK = 16'h00fe;
	localparam logic [15:0] NAME_MSB = 16'h0080;
	localparam logic [15:0] GAIN_RESET = 16'h2000;
	localparam logic [15:0] GAIN_MAX = 16'h2666;
	localparam logic [15:0] GAIN_MIN = 16'h1999;
	localparam logic [15:0] OFS_RESET = 16'h0000;
	// Linear-format exponent field, five bits two's complement in bits 15:11
	localparam logic [4:0] EXP_VOUT_OFS = 5'h14;
	localparam logic [4:0] EXP_VIN_OFS = 5'h1d;
	localparam logic [4:0] EXP_IOUT_OFS = 5'h1c;
	// Pin assignment codes
	localparam logic [3:0] PIN_ONOFF_PG = 4'h0;
	localparam logic [3:0] PIN_TRIM_PG = 4'h1;
	localparam logic [3:0] PIN_TRIM_ONOFF = 4'h2;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		PSM_FN_ONOFF = 2'b00,
		PSM_FN_TRIM = 2'b01,
		PSM_FN_PGOOD = 2'b10
	} psm_pin_fn_t;
	typedef struct packed {
		logic [15:0] vin;
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] temp;
	} psm_telem_t;
	typedef struct packed {
		logic otFault;
		logic otWarn;
		logic badCmd;
		logic badData;
		logic pecFail;
	} psm_events_t;
endpackage

// ==== hdl/psm_status_mfr_regs.sv ====
// Purpose: Status, telemetry and calibration register bank of a power module
// Assumes: Command decoder gives one-cycle write/read strobes with a command code
// Notes: Output and input voltage offsets are loaded from non-volatile store after reset; their gains only when in range
`timescale 1ns/10ps
module psm_status_mfr_regs
	import psm_pkg::*;
#(
	parameter logic [5:0] MODULE_NAME = 6'h2a, // Arbitrary value, isolated format
	parameter logic [7:0] FW_REVISION = 8'h10, // Arbitrary value
	parameter bit DROOP_VARIANT = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] wrData,
	input wire psm_events_t events,
	input wire psm_telem_t telem,
	input wire logic [15:0] nvVoutGain,
	input wire logic [15:0] nvVoutOfs,
	input wire logic [15:0] nvVinGain,
	input wire logic [15:0] nvVinOfs,
	input wire logic alertActive,
	output logic [15:0] rdData,
	output logic rdValid,
	output logic writeRejected,
	output logic answerOwnAddr,
	output logic answerAlertAddr,
	output psm_pin_fn_t firstPinFn,
	output psm_pin_fn_t secondPinFn,
	output logic [15:0] voutGainCal,
	output logic [15:0] voutOfsCal,
	output logic [15:0] vinGainCal,
	output logic [15:0] vinOfsCal,
	output logic [15:0] ioutGainCal,
	output logic [15:0] ioutOfsCal
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] tempStatus_reg, tempStatus_next;
	logic [7:0] commStatus_reg, commStatus_next;
	logic [15:0] devType_reg, devType_next;
	logic [15:0] voutGain_reg, voutGain_next, voutOfs_reg, voutOfs_next;
	logic [15:0] vinGain_reg, vinGain_next, vinOfs_reg, vinOfs_next;
	logic [15:0] ioutGain_reg, ioutGain_next, ioutOfs_reg, ioutOfs_next;
	logic [7:0] pinCfg_reg, pinCfg_next;
	logic [15:0] rdData_reg, rdData_next;
	logic rdValid_reg, rdValid_next, wrRej_reg, wrRej_next;
	logic ownAddr_reg, ownAddr_next, araAddr_reg, araAddr_next;
	psm_pin_fn_t pin1_reg, pin1_next, pin2_reg, pin2_next;
	logic locked, gainOk, wrCal;
	logic [7:0] tempEv, commEv, tempClr, commClr;
	logic [3:0] pinCode;
	logic nvLoaded_reg, nvLoaded_next, nvLoadNow;
	logic [15:0] nameWord;

	// Gain range check shared by the three gain registers
	assign gainOk = (wrData >= GAIN_MIN) && (wrData <= GAIN_MAX);
	assign locked = devType_reg[WPE_BIT];
	assign pinCode = wrData[3:0];
	// Hardware event and host clear vectors
	always_comb begin
		tempEv = 8'h00;
		commEv = 8'h00;
		tempEv[OVER_TEMP_FAULT_FLAG_BIT] = events.otFault;
		tempEv[OVER_TEMP_WARN_FLAG_BIT] = events.otWarn;
		commEv[BAD_CMD_BIT] = events.badCmd;
		commEv[BAD_DATA_BIT] = events.badData;
		commEv[PEC_FAIL_BIT] = events.pecFail;
		tempClr = (wrStb && cmdCode == CMD_TEMP_STATUS) ? wrData[7:0] : 8'h00;
		commClr = (wrStb && cmdCode == CMD_COMM_STATUS) ? wrData[7:0] : 8'h00;
		wrCal = wrStb && !locked;
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		// Set wins over clear; unsupported bits masked to zero
		tempStatus_next = ((tempStatus_reg & ~tempClr) | tempEv) & TEMP_MASK;
		commStatus_next = ((commStatus_reg & ~commClr) | commEv) & COMM_MASK;
		devType_next = devType_reg;
		voutGain_next = voutGain_reg;
		voutOfs_next = voutOfs_reg;
		vinGain_next = vinGain_reg;
		vinOfs_next = vinOfs_reg;
		ioutGain_next = ioutGain_reg;
		ioutOfs_next = ioutOfs_reg;
		pinCfg_next = pinCfg_reg;
		// Voltage calibration factors come from the non-volatile store once after reset; gains only if in range
		if (nvLoadNow) begin
			if (nvVoutGain >= GAIN_MIN && nvVoutGain <= GAIN_MAX) begin
				voutGain_next = nvVoutGain;
			end
			if (nvVinGain >= GAIN_MIN && nvVinGain <= GAIN_MAX) begin
				vinGain_next = nvVinGain;
			end
			voutOfs_next = nvVoutOfs;
			vinOfs_next = nvVinOfs;
		end
		wrRej_next = 1'b0;
		if (wrStb) begin
			unique case (cmdCode)
				CMD_DEV_TYPE: begin
					// Only the protect bit is writable; name stays fixed
					devType_next[WPE_BIT] = wrData[WPE_BIT];
				end
				CMD_VOUT_GAIN: begin
					if (wrCal && gainOk) voutGain_next = wrData;
					else wrRej_next = 1'b1;
				end
				CMD_VIN_GAIN: begin
					if (wrCal && gainOk) vinGain_next = wrData;
					else wrRej_next = 1'b1;
				end
				CMD_IOUT_GAIN: begin
					if (wrCal && gainOk) ioutGain_next = wrData;
					else wrRej_next = 1'b1;
				end
				CMD_VOUT_OFS: begin
					if (wrCal && wrData[15:11] == EXP_VOUT_OFS) voutOfs_next = wrData;
					else wrRej_next = 1'b1;
				end
				CMD_VIN_OFS: begin
					if (wrCal && wrData[15:11] == EXP_VIN_OFS) vinOfs_next = wrData;
					else wrRej_next = 1'b1;
				end
				CMD_IOUT_OFS: begin
					if (wrCal && wrData[15:11] == EXP_IOUT_OFS) ioutOfs_next = wrData;
					else wrRej_next = 1'b1;
				end
				CMD_PIN_CFG: begin
					// Droop-share variants refuse any code but 0000
					if (pinCode > PIN_TRIM_ONOFF || (DROOP_VARIANT && pinCode != PIN_ONOFF_PG))
						wrRej_next = 1'b1;
					else
						pinCfg_next = wrData[7:0] & PIN_CFG_MASK;
				end
				CMD_FW_REV, CMD_VIN_READ, CMD_VOUT_READ, CMD_IOUT_READ, CMD_TEMP_READ: begin
					wrRej_next = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// Read mux and pin/address decode
	always_comb begin
		rdValid_next = rdStb;
		rdData_next = rdData_reg;
		if (rdStb) begin
			unique case (cmdCode)
				CMD_TEMP_STATUS: rdData_next = {8'h00, tempStatus_reg};
				CMD_COMM_STATUS: rdData_next = {8'h00, commStatus_reg};
				CMD_VIN_READ: rdData_next = telem.vin;
				CMD_VOUT_READ: rdData_next = telem.vout;
				CMD_IOUT_READ: rdData_next = telem.iout;
				CMD_TEMP_READ: rdData_next = telem.temp;
				CMD_DEV_TYPE: rdData_next = (devType_reg | nameWord) & DEV_TYPE_MASK;
				CMD_VOUT_GAIN: rdData_next = voutGain_reg;
				CMD_VOUT_OFS: rdData_next = voutOfs_reg;
				CMD_VIN_GAIN: rdData_next = vinGain_reg;
				CMD_VIN_OFS: rdData_next = vinOfs_reg;
				CMD_IOUT_GAIN: rdData_next = ioutGain_reg;
				CMD_IOUT_OFS: rdData_next = ioutOfs_reg;
				CMD_FW_REV: rdData_next = {8'h00, FW_REVISION};
				CMD_PIN_CFG: rdData_next = {8'h00, pinCfg_reg & PIN_CFG_MASK};
				default: rdData_next = 16'h0000;
			endcase
		end
		// Alert-response address behaviour
		ownAddr_next = !(alertActive && pinCfg_reg[ARA_BIT]);
		araAddr_next = alertActive && pinCfg_reg[ARA_BIT];
		unique case (pinCfg_reg[3:0])
			PIN_TRIM_PG: begin
				pin1_next = PSM_FN_TRIM;
				pin2_next = PSM_FN_PGOOD;
			end
			PIN_TRIM_ONOFF: begin
				pin1_next = PSM_FN_TRIM;
				pin2_next = PSM_FN_ONOFF;
			end
			default: begin
				pin1_next = PSM_FN_ONOFF;
				pin2_next = PSM_FN_PGOOD;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			tempStatus_reg <= 8'h00;
			commStatus_reg <= 8'h00;
			devType_reg <= 16'h0000;
			voutGain_reg <= GAIN_RESET;
			voutOfs_reg <= OFS_RESET;
			vinGain_reg <= GAIN_RESET;
			vinOfs_reg <= OFS_RESET;
			ioutGain_reg <= GAIN_RESET;
			ioutOfs_reg <= OFS_RESET;
			pinCfg_reg <= PIN_CFG_RESET;
			rdData_reg <= 16'h0000;
			rdValid_reg <= 1'b0;
			wrRej_reg <= 1'b0;
			ownAddr_reg <= 1'b1;
			araAddr_reg <= 1'b0;
			pin1_reg <= PSM_FN_ONOFF;
			pin2_reg <= PSM_FN_PGOOD;
		end else if (clkEn) begin
			tempStatus_reg <= tempStatus_next;
			commStatus_reg <= commStatus_next;
			devType_reg <= devType_next;
			voutGain_reg <= voutGain_next;
			voutOfs_reg <= voutOfs_next;
			vinGain_reg <= vinGain_next;
			vinOfs_reg <= vinOfs_next;
			ioutGain_reg <= ioutGain_next;
			ioutOfs_reg <= ioutOfs_next;
			pinCfg_reg <= pinCfg_next;
			rdData_reg <= rdData_next;
			rdValid_reg <= rdValid_next;
			wrRej_reg <= wrRej_next;
			ownAddr_reg <= ownAddr_next;
			araAddr_reg <= araAddr_next;
			pin1_reg <= pin1_next;
			pin2_reg <= pin2_next;
		end
	end

	// Load marker: the store is copied once, in the first enabled cycle after reset
	assign nvLoaded_next = 1'b1;
	assign nvLoadNow = !nvLoaded_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			nvLoaded_reg <= 1'b0;
		end else if (clkEn) begin
			nvLoaded_reg <= nvLoaded_next;
		end
	end
	// Name field is fixed by the build; MSB forced for isolated units
	assign nameWord = {8'h00, MODULE_NAME, 2'b00} | NAME_MSB;

	assign rdData = rdData_reg;
	assign rdValid = rdValid_reg;
	assign writeRejected = wrRej_reg;
	assign answerOwnAddr = ownAddr_reg;
	assign answerAlertAddr = araAddr_reg;
	assign firstPinFn = pin1_reg;
	assign secondPinFn = pin2_reg;
	assign voutGainCal = voutGain_reg;
	assign voutOfsCal = voutOfs_reg;
	assign vinGainCal = vinGain_reg;
	assign vinOfsCal = vinOfs_reg;
	assign ioutGainCal = ioutGain_reg;
	assign ioutOfsCal = ioutOfs_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence calWrLocked;
		wrStb && clkEn && locked && cmdCode == CMD_VOUT_GAIN;
	endsequence
	lock_blocks_cal_a: assert property (@(posedge clk) disable iff (rst)
		calWrLocked |=> $stable(voutGainCal) && writeRejected)
		else $error("Calibration write passed while protected");
	temp_mask_zero_a: assert property (@(posedge clk) disable iff (rst)
		(tempStatus_reg & ~TEMP_MASK) == 8'h00)
		else $error("Unsupported temperature status bit set");
	comm_mask_zero_a: assert property (@(posedge clk) disable iff (rst)
		(commStatus_reg & ~COMM_MASK) == 8'h00)
		else $error("Unsupported comm status bit set");
	ot_set_wins_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && events.otFault |=> tempStatus_reg[OVER_TEMP_FAULT_FLAG_BIT])
		else $error("Over-temperature fault not latched");
	gain_range_a: assert property (@(posedge clk) disable iff (rst)
		voutGainCal >= GAIN_MIN && voutGainCal <= GAIN_MAX)
		else $error("Output voltage gain out of range");
	ara_excl_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && alertActive && pinCfg_reg[ARA_BIT] |=> answerAlertAddr && !answerOwnAddr)
		else $error("Alert address behaviour wrong");
	pin_hi_zero_a: assert property (@(posedge clk) disable iff (rst)
		pinCfg_reg[7:5] == 3'b000)
		else $error("Pin config reserved bits set");
	pin_map_trim_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && pinCfg_reg[3:0] == PIN_TRIM_ONOFF |=> secondPinFn == PSM_FN_ONOFF)
		else $error("Second pin not mapped to on/off");
	droop_only0_a: assert property (@(posedge clk) disable iff (rst)
		DROOP_VARIANT |-> pinCfg_reg[3:0] == PIN_ONOFF_PG)
		else $error("Droop variant took non-zero pin code");
	nv_load_ofs_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && nvLoadNow && !wrStb |=> vinOfsCal == $past(nvVinOfs))
		else $error("Input voltage offset not loaded from store");
	own_addr_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && !pinCfg_reg[ARA_BIT] |=> answerOwnAddr && !answerAlertAddr)
		else $error("Own address dropped with alert response off");
	comm_clear_a: assert property (@(posedge clk) disable iff (rst)
		clkEn && commClr[BAD_CMD_BIT] && !events.badCmd |=> !commStatus_reg[BAD_CMD_BIT])
		else $error("Bad command flag not cleared");
endmodule

// ==== testbench/psm_host_model.sv ====
// Purpose: Behavioural host that issues command accesses to the register bank
// Assumes: One access in flight; request held up to the edge that takes it
// Notes: Released code and data lines show the inverse of their last value
`timescale 1ns/10ps
module psm_host_model
	import psm_pkg::*;
(
	input wire logic clk,
	input wire logic [15:0] rdData,
	input wire logic rdValid,
	input wire logic writeRejected,
	output logic wrStb,
	output logic rdStb,
	output logic [7:0] cmdCode,
	output logic [15:0] wrData
);
	// Idle bus at time zero
	initial begin
		wrStb = 1'b0;
		rdStb = 1'b0;
		cmdCode = 8'h00;
		wrData = 16'h0000;
	end
	// One access; writes return 1 if refused, reads return the read data
	task automatic access(input bit wr, input logic [7:0] cmd, input logic [15:0] d,
		output logic [15:0] res);
		res = wr ? 16'h0000 : 16'hxxxx;
		@(posedge clk);
		#1;
		wrStb = wr;
		rdStb = !wr;
		cmdCode = cmd;
		wrData = d;
		@(posedge clk);
		#1;
		wrStb = 1'b0;
		rdStb = 1'b0;
		cmdCode = ~cmd;
		wrData = ~d;
		repeat (2) begin
			if (wr && writeRejected === 1'b1) res = 16'h0001;
			if (!wr && rdValid === 1'b1) res = rdData;
			@(posedge clk);
			#1;
		end
	endtask
endmodule

// ==== testbench/psm_status_mfr_regs_test.sv ====
// Purpose: Self-checking bench of the status and calibration register bank
// Assumes: Answers are registered on the accepting edge
// Notes: A second instance is the droop-share variant
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
`define ACC(w, c, d, e) begin u_psm_host_model.access(w, c, d, res); \
	`CHK($sformatf("cmd %h", c), e, res) end
module psm_status_mfr_regs_test
	import psm_pkg::*;
();
	typedef struct {bit wr; logic [7:0] cmd; logic [15:0] d; logic [15:0] exp;} psm_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic alertActive = 1'b0;
	logic wrStb, rdStb, writeRejected, rdValid, answerOwnAddr, answerAlertAddr;
	logic [7:0] cmdCode;
	logic [15:0] wrData, rdData, res, voutGainCal;
	logic clkEn = 1'b1;
	logic [15:0] nvVoutGain = 16'h2000;
	logic [15:0] nvVoutOfs = 16'h0000;
	logic [15:0] nvVinGain = 16'h2000;
	logic [15:0] nvVinOfs = 16'he804;
	logic [15:0] voutOfsCal, vinGainCal, vinOfsCal, ioutGainCal, ioutOfsCal;
	psm_events_t events = '0;
	psm_telem_t telem = '{vin: 16'h1111, vout: 16'h2222, iout: 16'h3333, temp: 16'h4444};
	psm_pin_fn_t firstPinFn, secondPinFn, droopFirstFn;
	psm_pin_fn_t fn1[3] = '{PSM_FN_ONOFF, PSM_FN_TRIM, PSM_FN_TRIM};
	psm_pin_fn_t fn2[3] = '{PSM_FN_PGOOD, PSM_FN_PGOOD, PSM_FN_ONOFF};
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	// ----------------------------------------
	// Ordinary accesses: write gives refusal flag, read gives data
	// ----------------------------------------
	psm_row_t rows[30] = '{
		'{0, CMD_VOUT_GAIN, 0, 16'h2000}, '{0, CMD_VIN_GAIN, 0, 16'h2000},
		'{0, CMD_PIN_CFG, 0, 0}, '{0, CMD_DEV_TYPE, 0, 16'h0094},
		'{1, CMD_VOUT_GAIN, 16'h2666, 0}, '{1, CMD_VOUT_GAIN, 16'h2667, 1},
		'{0, CMD_VOUT_GAIN, 0, 16'h2666}, '{1, CMD_VIN_GAIN, 16'h1998, 1},
		'{1, CMD_IOUT_GAIN, 16'h1999, 0}, '{0, CMD_IOUT_GAIN, 0, 16'h1999},
		'{1, CMD_VOUT_OFS, 16'ha005, 0}, '{0, CMD_VOUT_OFS, 0, 16'ha005},
		'{1, CMD_VIN_OFS, 16'ha005, 1}, '{1, CMD_VIN_OFS, 16'he803, 0},
		'{1, CMD_IOUT_OFS, 16'he003, 0}, '{0, CMD_IOUT_OFS, 0, 16'he003},
		'{1, CMD_FW_REV, 0, 1}, '{0, CMD_FW_REV, 0, 16'h003c},
		'{1, CMD_PIN_CFG, 16'h0003, 1}, '{0, CMD_VIN_READ, 0, 16'h1111},
		'{0, CMD_VOUT_READ, 0, 16'h2222}, '{0, CMD_IOUT_READ, 0, 16'h3333},
		'{0, CMD_TEMP_READ, 0, 16'h4444}, '{1, CMD_VIN_READ, 0, 1},
		'{0, 8'h55, 0, 0}, '{1, CMD_DEV_TYPE, 16'h0002, 0},
		'{0, CMD_DEV_TYPE, 0, 16'h0096}, '{1, CMD_VOUT_GAIN, 16'h2000, 1},
		'{1, CMD_DEV_TYPE, 0, 0}, '{1, CMD_VOUT_GAIN, 16'h2100, 0}
	};
	// Name code 0x05 and revision 0x3c are arbitrary; the name MSB must read as one
	psm_status_mfr_regs #(.MODULE_NAME(6'h05), .FW_REVISION(8'h3c)) u_psm_status_mfr_regs (
		.clk, .rst, .clkEn, .wrStb, .rdStb, .cmdCode, .wrData, .events, .telem, .nvVoutGain,
		.nvVoutOfs, .nvVinGain, .nvVinOfs, .alertActive, .rdData, .rdValid, .writeRejected,
		.answerOwnAddr, .answerAlertAddr, .firstPinFn, .secondPinFn, .voutGainCal, .voutOfsCal,
		.vinGainCal, .vinOfsCal, .ioutGainCal, .ioutOfsCal);
	psm_status_mfr_regs #(.DROOP_VARIANT(1'b1)) u_psm_status_mfr_regs_droop (.clk, .rst,
		.clkEn, .wrStb, .rdStb, .cmdCode, .wrData, .events, .telem, .nvVoutGain, .nvVoutOfs,
		.nvVinGain, .nvVinOfs, .alertActive, .rdData(), .rdValid(), .writeRejected(),
		.answerOwnAddr(), .answerAlertAddr(), .firstPinFn(droopFirstFn), .secondPinFn(),
		.voutGainCal(), .voutOfsCal(), .vinGainCal(), .vinOfsCal(), .ioutGainCal(),
		.ioutOfsCal());
	psm_host_model u_psm_host_model (.clk, .rdData, .rdValid, .writeRejected, .wrStb, .rdStb,
		.cmdCode, .wrData);
	// Clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			n_errors++;
			end_of_test();
		end
	end
	// Verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 30; i++) begin
			`ACC(rows[i].wr, rows[i].cmd, rows[i].d, rows[i].exp)
		end
		$display("table done");
		// Calibration outputs after the table
		`CHK("voutOfs", 16'ha005, voutOfsCal)
		`CHK("vinGain", 16'h2000, vinGainCal)
		`CHK("vinOfs", 16'he803, vinOfsCal)
		`CHK("ioutGain", 16'h1999, ioutGainCal)
		`CHK("ioutOfs", 16'he003, ioutOfsCal)
		// Clock enable low: a write is not taken
		clkEn = 1'b0;
		`ACC(1, CMD_VOUT_GAIN, 16'h2200, 0)
		clkEn = 1'b1;
		`ACC(0, CMD_VOUT_GAIN, 0, 16'h2100)
		$display("enable done");
		events = '1;
		@(posedge clk);
		#1;
		events = '0;
		`ACC(0, CMD_TEMP_STATUS, 0, 16'h00c0)
		`ACC(0, CMD_COMM_STATUS, 0, 16'h00e0)
		`ACC(1, CMD_TEMP_STATUS, 16'h0040, 0)
		`ACC(0, CMD_TEMP_STATUS, 0, 16'h0080)
		`ACC(1, CMD_COMM_STATUS, 16'h00ff, 0)
		`ACC(0, CMD_COMM_STATUS, 0, 16'h0000)
		// Event and clear on one edge: the event wins
		events.otFault = 1'b1;
		fork
			`ACC(1, CMD_TEMP_STATUS, 16'h0080, 0)
			begin
				repeat (2) @(posedge clk);
				#1;
				events.otFault = 1'b0;
			end
		join
		`ACC(0, CMD_TEMP_STATUS, 0, 16'h0080)
		$display("status done");
		for (int c = 0; c < 3; c++) begin
			u_psm_host_model.access(1'b1, CMD_PIN_CFG, 16'(c), res);
			`CHK("firstPin", fn1[c], firstPinFn)
			`CHK("secondPin", fn2[c], secondPinFn)
			`CHK("droopPin", PSM_FN_ONOFF, droopFirstFn)
		end
		alertActive = 1'b1;
		`ACC(1, CMD_PIN_CFG, 16'h0000, 0)
		`CHK("ownAddr", 1'b1, answerOwnAddr)
		`ACC(1, CMD_PIN_CFG, 16'h0010, 0)
		`CHK("ownAddr", 1'b0, answerOwnAddr)
		`CHK("alertAddr", 1'b1, answerAlertAddr)
		alertActive = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("ownAddr", 1'b1, answerOwnAddr)
		$display("pins done");
		`ACC(1, CMD_PIN_CFG, 16'h0012, 0)
		rst = 1'b1;
		@(posedge clk);
		#1;
		rst = 1'b0;
		`CHK("gainCal", 16'h2000, voutGainCal)
		`CHK("firstPin", PSM_FN_ONOFF, firstPinFn)
		`ACC(0, CMD_PIN_CFG, 0, 16'h0000)
		`ACC(0, CMD_DEV_TYPE, 0, 16'h0094)
		`CHK("vinOfsLoad", 16'he804, vinOfsCal)
		`CHK("ioutGainRst", 16'h2000, ioutGainCal)
		$display("reset done");
		end_of_test();
	end
endmodule
